// ==== hdl/clc_pkg.sv ====
package clc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int RATE_W = 18;
  localparam int KHZ_W = 7;
  localparam int MV_W = 6;

  // register byte addresses
  localparam logic [ADDR_W-1:0] CFG_ADDR = 8'h88;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'hc0;
  localparam logic [ADDR_W-1:0] DECODED_ADDR = 8'hc4;
  localparam logic [DATA_W-1:0] CFG_RESET = 32'h0000_0000;

  // field positions of closed_loop_settings_a
  localparam int ACC_LSB = 25;
  localparam int DEC_SRC_BIT = 24;
  localparam int DEC_LSB = 19;
  localparam int RATE_CODE_W = 5;
  localparam int PWM_FREQ_LSB = 15;
  localparam int PWM_FREQ_W = 4;
  localparam int PWM_MODE_BIT = 14;
  localparam int PHASE_SEL_LSB = 12;
  localparam int PHASE_SEL_W = 2;
  localparam int DIV_LSB = 8;
  localparam int DIV_W = 4;
  localparam int STOP_CFG_BIT = 7;
  localparam int BEMF_THR_LSB = 4;
  localparam int BEMF_THR_W = 3;
  localparam int SURGE_EN_BIT = 3;
  localparam int DEADTIME_EN_BIT = 2;
  localparam int SPEED_BYPASS_BIT = 1;

  // status register layout
  localparam int ST_FIRST_RUN = 0;
  localparam int ST_GATE = 1;
  localparam int ST_PWM_BAD = 2;
  localparam int ST_THR_BAD = 3;
  localparam int ST_SEL_BAD = 4;
  localparam int ST_DEC_VALID = 5;
  localparam int ST_COAST = 6;
  localparam int ST_KHZ_LSB = 8;

  // switching frequency: base plus step per code
  localparam logic [KHZ_W-1:0] PWM_BASE_KHZ = 7'h0a;
  localparam logic [KHZ_W-1:0] PWM_STEP_KHZ = 7'h05;
  localparam logic [PWM_FREQ_W-1:0] PWM_CODE_MAX = 4'ha;

  typedef enum logic [1:0] {
    SEL_BOTH = 2'b00,
    SEL_CLOSED_ONLY = 2'b01,
    SEL_FIRST_RUN = 2'b10,
    SEL_NA = 2'b11
  } clc_phase_sel_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ANSWER = 2'b01
  } clc_bus_state_t;

  // back-emf thresholds in mV for codes 0..5
  localparam logic [MV_W-1:0] THR_MV_0 = 6'h01;
  localparam logic [MV_W-1:0] THR_MV_1 = 6'h02;
  localparam logic [MV_W-1:0] THR_MV_2 = 6'h05;
  localparam logic [MV_W-1:0] THR_MV_3 = 6'h0a;
  localparam logic [MV_W-1:0] THR_MV_4 = 6'h14;
  localparam logic [MV_W-1:0] THR_MV_5 = 6'h1e;
  localparam logic [BEMF_THR_W-1:0] THR_CODE_MAX = 3'h5;

endpackage

// ==== hdl/clc_rate_decode.sv ====
`timescale 1ns/1ns
`default_nettype none
// rate in units of 0.5 Hz/s, so code 0 is 1
module clc_rate_decode (
  input wire logic [clc_pkg::RATE_CODE_W-1:0] code,
  output logic [clc_pkg::RATE_W-1:0] rate
);
  import clc_pkg::*;

  always_comb begin
    case (code)
      5'h00: rate = 18'h00001;
      5'h01: rate = 18'h00002;
      5'h02: rate = 18'h00005;
      5'h03: rate = 18'h0000a;
      5'h04: rate = 18'h0000f;
      5'h05: rate = 18'h00014;
      5'h06: rate = 18'h00028;
      5'h07: rate = 18'h00050;
      5'h08: rate = 18'h00078;
      5'h09: rate = 18'h000a0;
      5'h0a: rate = 18'h000c8;
      5'h0b: rate = 18'h00190;
      5'h0c: rate = 18'h00258;
      5'h0d: rate = 18'h00320;
      5'h0e: rate = 18'h003e8;
      5'h0f: rate = 18'h004b0;
      5'h10: rate = 18'h00578;
      5'h11: rate = 18'h00640;
      5'h12: rate = 18'h00708;
      5'h13: rate = 18'h007d0;
      5'h14: rate = 18'h00fa0;
      5'h15: rate = 18'h01f40;
      5'h16: rate = 18'h02ee0;
      5'h17: rate = 18'h03e80;
      5'h18: rate = 18'h04e20;
      5'h19: rate = 18'h09c40;
      5'h1a: rate = 18'h0ea60;
      5'h1b: rate = 18'h13880;
      5'h1c: rate = 18'h186a0;
      5'h1d: rate = 18'h1d4c0;
      default: rate = 18'h222e0;
    endcase
  end

endmodule
`default_nettype wire

// ==== hdl/clc_pulse_divider.sv ====
`timescale 1ns/1ns
`default_nettype none
// toggles its output once per divisor input pulses; codes 0 and 1 pass 1:1
module clc_pulse_divider (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic pulseIn,
  input wire logic [clc_pkg::DIV_W-1:0] divisor,
  output logic pulseOut
);
  import clc_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] count;
    logic out;
  } clc_div_state_t;

  clc_div_state_t state_q, state_d;

  always_comb begin
    state_d = state_q;
    if (!enable) begin
      // gated off: restart cleanly so the next burst starts in phase
      state_d.count = '0;
      state_d.out = 1'b0;
    end else if (pulseIn) begin
      if ((state_q.count + 4'h1) >= divisor) begin
        state_d.count = '0;
        state_d.out = ~state_q.out;
      end else begin
        state_d.count = state_q.count + 4'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign pulseOut = state_q.out;

endmodule
`default_nettype wire

// ==== hdl/clc_closed_loop_cfg.sv ====
`timescale 1ns/1ns
`default_nettype none
module clc_closed_loop_cfg (
  input wire logic clock,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [clc_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [clc_pkg::DATA_W-1:0] writedata,
  input wire logic [clc_pkg::BE_W-1:0] byteenable,
  output logic [clc_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  // control core state
  input wire logic closedLoop,
  input wire logic motorDriven,
  input wire logic wakeUp,
  input wire logic [clc_pkg::MV_W-1:0] bemfMv,
  input wire logic rawSpeedPulse,
  // applied settings
  output logic speedPulseOut,
  output logic [clc_pkg::KHZ_W-1:0] pwmFreqKhz,
  output logic pwmDiscontinuous,
  output logic surgeGuardOn,
  output logic deadTimeCompOn,
  output logic torqueMode,
  output logic [clc_pkg::RATE_W-1:0] decelRate,
  output logic decelRateValid
);
  import clc_pkg::*;

  typedef struct packed {
    clc_bus_state_t bus;
    logic waitReq;
    logic [DATA_W-1:0] readData;
    logic [DATA_W-1:0] cfg;
    logic firstRun;
    logic drivenPrev;
    logic coasting;
    logic gate;
    logic pulse;
    logic [KHZ_W-1:0] khz;
    logic pwmBad;
    logic thrBad;
    logic selBad;
    logic discont;
    logic surge;
    logic deadTime;
    logic torque;
    logic [RATE_W-1:0] rate;
    logic rateValid;
  } clc_state_t;

  clc_state_t state_q, state_d;

  logic [RATE_CODE_W-1:0] decCode;
  logic [RATE_CODE_W-1:0] accCode;
  logic [RATE_W-1:0] decTable;
  logic [RATE_W-1:0] accTable;
  logic dividedPulse;
  logic [PWM_FREQ_W-1:0] pwmCode;
  logic [PHASE_SEL_W-1:0] selCode;
  logic [BEMF_THR_W-1:0] thrCode;
  logic [DIV_W-1:0] divCode;
  logic gateNext;
  logic stopHold;

  function automatic logic addrIs(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] target
  );
    addrIs = (addr == target);
  endfunction

  function automatic logic [DATA_W-1:0] mergeBytes(
    input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] data,
    input logic [BE_W-1:0] be
  );
    logic [DATA_W-1:0] res;
    res = old;
    for (int i = 0; i < BE_W; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    mergeBytes = res;
  endfunction

  // unsupported threshold codes fall back to the highest threshold
  function automatic logic [MV_W-1:0] thrMv(
    input logic [BEMF_THR_W-1:0] code
  );
    case (code)
      3'h0: thrMv = THR_MV_0;
      3'h1: thrMv = THR_MV_1;
      3'h2: thrMv = THR_MV_2;
      3'h3: thrMv = THR_MV_3;
      3'h4: thrMv = THR_MV_4;
      default: thrMv = THR_MV_5;
    endcase
  endfunction

  assign decCode = state_q.cfg[DEC_LSB +: RATE_CODE_W];
  assign accCode = state_q.cfg[ACC_LSB +: RATE_CODE_W];
  assign pwmCode = state_q.cfg[PWM_FREQ_LSB +: PWM_FREQ_W];
  assign selCode = state_q.cfg[PHASE_SEL_LSB +: PHASE_SEL_W];
  assign thrCode = state_q.cfg[BEMF_THR_LSB +: BEMF_THR_W];
  assign divCode = state_q.cfg[DIV_LSB +: DIV_W];

  clc_rate_decode u_dec_table (
    .code(decCode),
    .rate(decTable)
  );

  // same table shape serves the accel field for the alternate source
  clc_rate_decode u_acc_table (
    .code(accCode),
    .rate(accTable)
  );

  clc_pulse_divider u_divider (
    .clock(clock),
    .rst_b(rst_b),
    .enable(state_q.gate),
    .pulseIn(rawSpeedPulse),
    .divisor(divCode),
    .pulseOut(dividedPulse)
  );

  // loop-phase part of the speed pulse gate
  always_comb begin
    case (clc_phase_sel_t'(selCode))
      SEL_BOTH: gateNext = 1'b1;
      SEL_CLOSED_ONLY: gateNext = closedLoop;
      SEL_FIRST_RUN: gateNext = closedLoop || state_q.firstRun;
      default: gateNext = 1'b0;
    endcase
  end

  // stop part: either while driven, or through the coast down
  always_comb begin
    if (state_q.cfg[STOP_CFG_BIT]) begin
      stopHold = motorDriven || state_q.coasting;
    end else begin
      stopHold = motorDriven;
    end
  end

  always_comb begin
    state_d = state_q;

    // bus: one wait state, then the answer stands for one cycle
    case (state_q.bus)
      BUS_IDLE: begin
        state_d.waitReq = 1'b1;
        if (read || write) begin
          state_d.bus = BUS_ANSWER;
          state_d.waitReq = 1'b0;
          state_d.readData = '0;
          if (read) begin
            if (addrIs(address, CFG_ADDR)) begin
              state_d.readData = state_q.cfg;
            end else if (addrIs(address, STATUS_ADDR)) begin
              state_d.readData[ST_FIRST_RUN] = state_q.firstRun;
              state_d.readData[ST_GATE] = state_q.gate;
              state_d.readData[ST_PWM_BAD] = state_q.pwmBad;
              state_d.readData[ST_THR_BAD] = state_q.thrBad;
              state_d.readData[ST_SEL_BAD] = state_q.selBad;
              state_d.readData[ST_DEC_VALID] = state_q.rateValid;
              state_d.readData[ST_COAST] = state_q.coasting;
              state_d.readData[ST_KHZ_LSB +: KHZ_W] = state_q.khz;
            end else if (addrIs(address, DECODED_ADDR)) begin
              state_d.readData[RATE_W-1:0] = state_q.rate;
            end
          end
        end
      end
      BUS_ANSWER: begin
        state_d.bus = BUS_IDLE;
        state_d.waitReq = 1'b1;
        // the write lands on the edge where waitrequest is seen low
        if (write && addrIs(address, CFG_ADDR)) begin
          state_d.cfg = mergeBytes(state_q.cfg, writedata, byteenable);
        end
      end
      default: begin
        state_d.bus = BUS_IDLE;
        state_d.waitReq = 1'b1;
      end
    endcase

    // switching frequency; reserved codes keep the last good setting
    if (pwmCode <= PWM_CODE_MAX) begin
      state_d.khz = KHZ_W'(PWM_BASE_KHZ + pwmCode * PWM_STEP_KHZ);
      state_d.pwmBad = 1'b0;
    end else begin
      state_d.pwmBad = 1'b1;
    end

    state_d.discont = state_q.cfg[PWM_MODE_BIT];
    state_d.surge = state_q.cfg[SURGE_EN_BIT];
    state_d.deadTime = state_q.cfg[DEADTIME_EN_BIT];
    state_d.torque = state_q.cfg[SPEED_BYPASS_BIT];
    state_d.thrBad = (thrCode > THR_CODE_MAX);
    state_d.selBad = (clc_phase_sel_t'(selCode) == SEL_NA);

    // decel rate: surge guard owns deceleration while it is on
    if (state_q.cfg[SURGE_EN_BIT]) begin
      state_d.rate = '0;
      state_d.rateValid = 1'b0;
    end else if (state_q.cfg[DEC_SRC_BIT]) begin
      state_d.rate = accTable;
      state_d.rateValid = 1'b1;
    end else begin
      state_d.rate = decTable;
      state_d.rateValid = 1'b1;
    end

    // first run after power-up or wake-up ends when driving stops
    state_d.drivenPrev = motorDriven;
    if (wakeUp) begin
      state_d.firstRun = 1'b1;
    end else if (state_q.drivenPrev && !motorDriven) begin
      state_d.firstRun = 1'b0;
    end

    // coasting holds the pulse after drive ends until bemf is low
    if (motorDriven) begin
      state_d.coasting = 1'b1;
    end else if (bemfMv < thrMv(thrCode)) begin
      state_d.coasting = 1'b0;
    end

    state_d.gate = gateNext && stopHold;
    state_d.pulse = dividedPulse;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q.bus <= BUS_IDLE;
      state_q.waitReq <= 1'b1;
      state_q.readData <= '0;
      state_q.cfg <= CFG_RESET;
      state_q.firstRun <= 1'b1;
      state_q.drivenPrev <= 1'b0;
      state_q.coasting <= 1'b0;
      state_q.gate <= 1'b0;
      state_q.pulse <= 1'b0;
      state_q.khz <= PWM_BASE_KHZ;
      state_q.pwmBad <= 1'b0;
      state_q.thrBad <= 1'b0;
      state_q.selBad <= 1'b0;
      state_q.discont <= 1'b0;
      state_q.surge <= 1'b0;
      state_q.deadTime <= 1'b0;
      state_q.torque <= 1'b0;
      state_q.rate <= '0;
      state_q.rateValid <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign readdata = state_q.readData;
  assign waitrequest = state_q.waitReq;
  assign speedPulseOut = state_q.pulse;
  assign pwmFreqKhz = state_q.khz;
  assign pwmDiscontinuous = state_q.discont;
  assign surgeGuardOn = state_q.surge;
  assign deadTimeCompOn = state_q.deadTime;
  assign torqueMode = state_q.torque;
  assign decelRate = state_q.rate;
  assign decelRateValid = state_q.rateValid;

endmodule
`default_nettype wire

// ==== testbench/clc_cfg_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module clc_cfg_monitor (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [clc_pkg::ADDR_W-1:0] address,
  input wire logic write,
  input wire logic [clc_pkg::DATA_W-1:0] writedata,
  input wire logic [clc_pkg::BE_W-1:0] byteenable,
  input wire logic waitrequest,
  input wire logic closedLoop,
  input wire logic motorDriven,
  input wire logic speedPulseOut,
  input wire logic [clc_pkg::KHZ_W-1:0] pwmFreqKhz,
  input wire logic pwmDiscontinuous,
  input wire logic surgeGuardOn,
  input wire logic deadTimeCompOn,
  input wire logic torqueMode,
  input wire logic [clc_pkg::RATE_W-1:0] decelRate,
  input wire logic decelRateValid
);
  import clc_pkg::*;
  logic [DATA_W-1:0] cfgQ;
  logic [DATA_W-1:0] cfgD;
  logic armQ;
  // shadow of the register, rebuilt from completed bus writes
  always_comb begin
    cfgD = cfgQ;
    if (write && !waitrequest && address == CFG_ADDR) begin
      for (int b = 0; b < BE_W; b++) begin
        if (byteenable[b]) begin
          cfgD[8*b +: 8] = writedata[8*b +: 8];
        end
      end
    end
  end
  // arm one edge late: outputs still hold reset values at the first edge
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfgQ <= CFG_RESET;
      armQ <= 1'b0;
    end else begin
      cfgQ <= cfgD;
      armQ <= 1'b1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  AST_MODE: assert property (armQ |-> pwmDiscontinuous == $past(cfgQ[14]))
    else $error("modulation mode wrong");
  AST_SURGE: assert property (armQ |-> surgeGuardOn == $past(cfgQ[3]))
    else $error("surge guard wrong");
  AST_DTC: assert property (armQ |-> deadTimeCompOn == $past(cfgQ[2]))
    else $error("dead-time comp wrong");
  AST_TORQUE: assert property (armQ |-> torqueMode == $past(cfgQ[1]))
    else $error("torque mode wrong");
  AST_KHZ: assert property (armQ && $past(cfgQ[18:15]) <= 4'ha |->
    pwmFreqKhz == 7'h0a + 7'h05 * $past(cfgQ[18:15]))
    else $error("switching frequency wrong");
  AST_DEC_OFF: assert property (armQ && $past(cfgQ[3]) |->
    !decelRateValid && decelRate == 18'h0) else $error("decel not off");
  AST_DEC_ON: assert property (armQ && !$past(cfgQ[3]) |-> decelRateValid)
    else $error("decel not valid");
  AST_DEC_MIN: assert property (armQ && $past(cfgQ[24:19]) == 6'h0 &&
    !$past(cfgQ[3]) |-> decelRate == 18'h1) else $error("slowest rate wrong");
  AST_SP_SEL: assert property ((cfgQ[13:12] == 2'h1 && !closedLoop)[*5]
    |-> !speedPulseOut) else $error("speed pulse in open loop");
  AST_SP_STOP: assert property ((!cfgQ[7] && !motorDriven)[*5]
    |-> !speedPulseOut) else $error("speed pulse while stopped");
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import clc_pkg::*;
  logic clock, rst_b, read, write, closedLoop, motorDriven, wakeUp;
  logic rawSpeedPulse, speedPulseOut, pwmDiscontinuous, surgeGuardOn;
  logic deadTimeCompOn, torqueMode, decelRateValid, waitrequest, spPrev;
  logic [ADDR_W-1:0] address;
  logic [DATA_W-1:0] writedata, readdata, q, expReg, d, st;
  logic [BE_W-1:0] byteenable, be;
  logic [MV_W-1:0] bemfMv;
  logic [KHZ_W-1:0] pwmFreqKhz, expKhz;
  logic [RATE_W-1:0] decelRate;
  int mismatches, num_checks, cycles, toggles;
  int rates[32] = '{1, 2, 5, 10, 15, 20, 40, 80, 120, 160, 200, 400, 600,
    800, 1000, 1200, 1400, 1600, 1800, 2000, 4000, 8000, 12000, 16000, 20000,
    40000, 60000, 80000, 100000, 120000, 140000, 140000};
  // sel div stop thr driven closed bemf wake pulses toggles
  int sp[16][10] = '{'{0,3,0,0,1,0,0,0,12,4}, '{0,0,0,0,1,0,0,0,4,4},
    '{0,1,0,0,1,0,0,0,4,4}, '{0,15,0,0,1,0,0,0,30,2}, '{1,1,0,0,1,0,0,0,4,0},
    '{1,1,0,0,1,1,0,0,4,4}, '{3,1,0,0,1,1,0,0,4,0}, '{2,1,0,0,1,0,0,0,4,4},
    '{2,1,0,0,0,0,0,0,0,0}, '{2,1,0,0,1,0,0,0,4,0}, '{2,1,0,0,1,1,0,0,4,4},
    '{2,1,0,0,1,0,0,1,4,4}, '{0,1,0,0,0,0,0,0,4,0}, '{0,1,1,2,1,0,0,0,4,4},
    '{0,1,1,2,0,0,5,0,4,4}, '{0,1,1,2,0,0,4,0,4,0}};
  clc_closed_loop_cfg u_clc_closed_loop_cfg (.clock(clock), .rst_b(rst_b),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .closedLoop(closedLoop), .motorDriven(motorDriven), .wakeUp(wakeUp),
    .bemfMv(bemfMv), .rawSpeedPulse(rawSpeedPulse),
    .speedPulseOut(speedPulseOut), .pwmFreqKhz(pwmFreqKhz),
    .pwmDiscontinuous(pwmDiscontinuous), .surgeGuardOn(surgeGuardOn),
    .deadTimeCompOn(deadTimeCompOn), .torqueMode(torqueMode),
    .decelRate(decelRate), .decelRateValid(decelRateValid));
  function automatic logic [31:0] exp_rate(input logic [31:0] r);
    if (r[3]) return 0;
    return rates[r[24] ? r[29:25] : r[23:19]];
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] dt, input logic [3:0] en, output logic [31:0] rd);
    @(posedge clock);
    address <= a;
    writedata <= dt;
    byteenable <= en;
    read <= !wr;
    write <= wr;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clock = 0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  // counted on the falling edge, away from the driving edge
  always @(negedge clock) begin
    if (speedPulseOut !== spPrev) toggles++;
    spPrev = speedPulseOut;
  end
  initial begin
    {read, write, closedLoop, motorDriven, wakeUp, rawSpeedPulse} = 6'h0;
    {rst_b, address, writedata, byteenable, bemfMv, spPrev} = 0;
    expReg = CFG_RESET;
    expKhz = 7'h0a;
    void'($urandom(10790));
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    bus(0, CFG_ADDR, 0, 4'hf, q);
    check("cfg reset", q, CFG_RESET);
    check("khz reset", pwmFreqKhz, expKhz);
    for (int i = 0; i < 48; i++) begin
      d = $urandom;
      d[18:15] = i[3:0];
      d[23:19] = i[4:0];
      be = (i < 32) ? 4'hf : 4'($urandom);
      bus(1, CFG_ADDR, d, be, q);
      for (int b = 0; b < 4; b++) if (be[b]) expReg[8*b +: 8] = d[8*b +: 8];
      if (expReg[18:15] <= 4'ha) expKhz = 7'h0a + 7'h05 * expReg[18:15];
      repeat (2) @(posedge clock);
      check("khz", pwmFreqKhz, expKhz);
      check("mode", pwmDiscontinuous, expReg[14]);
      check("surge", surgeGuardOn, expReg[3]);
      check("deadtime", deadTimeCompOn, expReg[2]);
      check("torque", torqueMode, expReg[1]);
      check("valid", decelRateValid, !expReg[3]);
      check("rate", decelRate, exp_rate(expReg));
      bus(0, CFG_ADDR, 0, 4'hf, q);
      check("readback", q, expReg);
      bus(0, DECODED_ADDR, 0, 4'hf, q);
      check("decoded", q, exp_rate(expReg));
      bus(0, STATUS_ADDR, 0, 4'hf, q);
      // motor never driven here: first run still armed, gate and coast off
      st = '0;
      st[ST_FIRST_RUN] = 1'b1;
      st[ST_PWM_BAD] = expReg[18:15] > 4'ha;
      st[ST_THR_BAD] = expReg[6:4] > 3'h5;
      st[ST_SEL_BAD] = expReg[13:12] == 2'h3;
      st[ST_DEC_VALID] = !expReg[3];
      st[ST_KHZ_LSB +: KHZ_W] = expKhz;
      check("status", q, st);
    end
    bus(1, 8'h40, $urandom, 4'hf, q);
    bus(1, STATUS_ADDR, 32'hffff_ffff, 4'hf, q);
    bus(0, 8'h40, 0, 4'hf, q);
    check("unmapped", q, 0);
    bus(0, CFG_ADDR, 0, 4'hf, q);
    check("kept", q, expReg);
    $display("test registers done");
    for (int r = 0; r < 16; r++) begin
      motorDriven <= sp[r][4];
      closedLoop <= sp[r][5];
      bemfMv <= sp[r][6];
      d = (sp[r][0] << 12) | (sp[r][1] << 8) | (sp[r][2] << 7) |
        (sp[r][3] << 4);
      bus(1, CFG_ADDR, d, 4'hf, q);
      if (sp[r][7] != 0) begin
        @(posedge clock);
        wakeUp <= 1'b1;
        @(posedge clock);
        wakeUp <= 1'b0;
      end
      repeat (5) @(posedge clock);
      toggles = 0;
      repeat (sp[r][8]) begin
        @(posedge clock);
        rawSpeedPulse <= 1'b1;
        @(posedge clock);
        rawSpeedPulse <= 1'b0;
      end
      repeat (6) @(posedge clock);
      check("toggles", toggles, sp[r][9]);
    end
    $display("test speed pulse done");
    end_of_test();
  end
endmodule
bind clc_closed_loop_cfg clc_cfg_monitor u_clc_cfg_monitor (.clock(clock),
  .rst_b(rst_b), .address(address), .write(write), .writedata(writedata),
  .byteenable(byteenable), .waitrequest(waitrequest), .closedLoop(closedLoop),
  .motorDriven(motorDriven), .speedPulseOut(speedPulseOut),
  .pwmFreqKhz(pwmFreqKhz), .pwmDiscontinuous(pwmDiscontinuous),
  .surgeGuardOn(surgeGuardOn), .deadTimeCompOn(deadTimeCompOn),
  .torqueMode(torqueMode), .decelRate(decelRate),
  .decelRateValid(decelRateValid));
`default_nettype wire
